// ### src/ic_top.sv
// interrupt controller of the 8-bit core: flags, enables, vectoring,
// context shadowing and wake from sleep, registers over apb
// assumes the core follows redirect/return strobes; timer0 gives one-cycle
// pulses on mclk_in, the peripheral irq a held level; pin change and the external pin are asynchronous
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/100ps
`default_nettype none
`include "ic_cfg.svh"
module ic_top (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic timer0_counter_ovf_in,
  input wire logic pin_change_in,
  input wire logic periph_irq_in,
  input wire logic ext_pin_in,
  input wire logic sleep_instr_in,
  input wire logic retire_in,
  input wire logic return_from_irq_instr_in,
  input wire ic_pkg::ic_ctx_s core_ctx_in,
  output logic flush_out,
  output logic push_pc_out,
  output logic pop_pc_out,
  output logic load_vec_out,
  output logic [14:0] vector_out,
  output logic restore_out,
  output ic_pkg::ic_ctx_s restore_ctx_out,
  output logic core_sleep_out,
  output logic [7:0] ctrl_out
);
  typedef struct packed {
    logic [7:0] ctrl;
    logic ext_edge_select;
    ic_pkg::ic_ctx_s shw;
    ic_pkg::ic_state_e fsm;
    logic ext_pend;
    logic [1:0] wq;
    logic flush;
    logic push;
    logic pop;
    logic ldvec;
    logic restore;
    logic sleeping;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
  } ic_top_s;
  ic_top_s st_q;
  ic_top_s st_d;
  logic q1;
  logic q4;
  logic ext_edge;
  logic req;
  logic wake_req;
  logic acc;
  logic wr_ctrl;
  logic pc_sync_q1;
  logic pc_sync_q2;
  logic pc_prev_q;
  logic pc_event;

  ic_qgen u_qgen (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .q1_out(q1),
    .q4_out(q4)
  );
  ic_edge u_edge (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .pin_in(ext_pin_in),
    .rise_sel_in(st_q.ext_edge_select),
    .edge_out(ext_edge)
  );

  // pin-change level crosses from the port domain through two flops
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pc_sync_q1 <= 1'b0;
      pc_sync_q2 <= 1'b0;
      pc_prev_q <= 1'b0;
    end
    else
    begin
      pc_sync_q1 <= pin_change_in;
      pc_sync_q2 <= pc_sync_q1;
      pc_prev_q <= pc_sync_q2;
    end
  end
  assign pc_event = pc_sync_q2 ^ pc_prev_q;

  // zero-wait apb slave: access phase always completes at once
  assign acc = psel_in & penable_in;
  assign wr_ctrl = acc & pwrite_in & (paddr_in == `IC_OFS_CTRL);

  function automatic logic [7:0] flag_upd(input logic [7:0] cur, input logic [7:0] wv,
                                          input logic wr, input logic [7:0] setv);
    // software write first, hardware set last so it wins
    logic [7:0] r;
    r = wr ? wv : cur;
    flag_upd = r | setv;
  endfunction

  // pending request: enables gate the flags, global gates req but not wake_req
  always_comb
  begin
    req = st_q.ctrl[`IC_B_GIE] &
          ((st_q.ctrl[`IC_B_T0IE] & st_q.ctrl[`IC_B_T0IF]) |
           (st_q.ctrl[`IC_B_EXIE] & st_q.ctrl[`IC_B_EXIF]) |
           (st_q.ctrl[`IC_B_PCIE] & st_q.ctrl[`IC_B_PCIF]) |
           (st_q.ctrl[`IC_B_PERIPH_GROUP_ENABLE] & periph_irq_in));
    wake_req = (st_q.ctrl[`IC_B_T0IE] & st_q.ctrl[`IC_B_T0IF]) |
               (st_q.ctrl[`IC_B_EXIE] & st_q.ctrl[`IC_B_EXIF]) |
               (st_q.ctrl[`IC_B_PCIE] & st_q.ctrl[`IC_B_PCIF]) |
               (st_q.ctrl[`IC_B_PERIPH_GROUP_ENABLE] & periph_irq_in);
  end

  always_comb
  begin
    logic [7:0] setv;
    logic [7:0] wv;
    setv = 8'h00;
    wv = pwdata_in[7:0];
    st_d = st_q;
    st_d.flush = 1'b0;
    st_d.push = 1'b0;
    st_d.pop = 1'b0;
    st_d.ldvec = 1'b0;
    st_d.restore = 1'b0;
    // edges may arrive in any q phase; held pending until q1 sample
    if (ext_edge)
      st_d.ext_pend = 1'b1;
    if (q1 && (st_q.ext_pend || ext_edge))
    begin
      setv[`IC_B_EXIF] = 1'b1;
      st_d.ext_pend = 1'b0;
    end
    setv[`IC_B_T0IF] = timer0_counter_ovf_in;
    // pin-change flag is read-only: software writes never touch it
    wv[`IC_B_PCIF] = st_q.ctrl[`IC_B_PCIF];
    setv[`IC_B_PCIF] = pc_event;
    st_d.ctrl = flag_upd(st_q.ctrl, wv, wr_ctrl, setv);
    // apb reads and non-control writes
    st_d.ready = 1'b0;
    st_d.slverr = 1'b0;
    if (psel_in && !penable_in)
    begin
      st_d.ready = 1'b1;
      st_d.rdata = 32'h0000_0000;
      case (paddr_in)
        `IC_OFS_CTRL: st_d.rdata[7:0] = st_q.ctrl;
        `IC_OFS_OPT: st_d.rdata[0] = st_q.ext_edge_select;
        `IC_OFS_CORE: st_d.rdata[1:0] = st_q.fsm;
        `IC_OFS_SHW_W: st_d.rdata[7:0] = st_q.shw.w;
        `IC_OFS_SHW_ST: st_d.rdata[7:0] = st_q.shw.st;
        `IC_OFS_SHW_BSR: st_d.rdata[7:0] = st_q.shw.bank_select_register;
        `IC_OFS_SHW_FSRL: st_d.rdata[7:0] = st_q.shw.fsrl;
        `IC_OFS_SHW_FSRH: st_d.rdata[7:0] = st_q.shw.fsrh;
        `IC_OFS_SHW_PCH: st_d.rdata[7:0] = st_q.shw.pch;
        `IC_OFS_PGRP: st_d.rdata = 32'h0000_0000;
        default: st_d.slverr = 1'b1;
      endcase
    end
    if (acc && pwrite_in)
    begin
      case (paddr_in)
        `IC_OFS_OPT: st_d.ext_edge_select = pwdata_in[0];
        `IC_OFS_SHW_W: st_d.shw.w = pwdata_in[7:0];
        `IC_OFS_SHW_ST: st_d.shw.st = pwdata_in[7:0];
        `IC_OFS_SHW_BSR: st_d.shw.bank_select_register = pwdata_in[7:0];
        `IC_OFS_SHW_FSRL: st_d.shw.fsrl = pwdata_in[7:0];
        `IC_OFS_SHW_FSRH: st_d.shw.fsrh = pwdata_in[7:0];
        `IC_OFS_SHW_PCH: st_d.shw.pch = pwdata_in[7:0];
        default: st_d.rdata = st_q.rdata;
      endcase
    end
    // sequencer: all but the sleep wake decided at q4 so entry lands on the next cycle
    case (st_q.fsm)
      ic_pkg::IC_RUN:
      begin
        if (q4 && return_from_irq_instr_in)
        begin
          st_d.pop = 1'b1;
          st_d.restore = 1'b1;
          st_d.ctrl[`IC_B_GIE] = 1'b1;
        end
        else if (q4 && req)
        begin
          st_d.flush = 1'b1;
          st_d.ctrl[`IC_B_GIE] = 1'b0;
          st_d.push = 1'b1;
          st_d.wq = 2'h0;
          st_d.fsm = ic_pkg::IC_ENTER;
          // status keeps timeout/powerdown bits out of the copy
          st_d.shw = core_ctx_in;
          st_d.shw.st = core_ctx_in.st & ~`IC_ST_KEEP_MASK;
        end
        else if (q4 && sleep_instr_in)
        begin
          st_d.sleeping = 1'b1;
          st_d.fsm = ic_pkg::IC_SLEEP;
        end
      end
      ic_pkg::IC_ENTER:
      begin
        // three q4 edges here stretch entry to twelve clock cycles
        if (q4)
        begin
          if (st_q.wq == `IC_ENTRY_WAIT)
          begin
            st_d.ldvec = 1'b1;
            st_d.fsm = ic_pkg::IC_RUN;
          end
          else
            st_d.wq = st_q.wq + 2'h1;
        end
      end
      ic_pkg::IC_SLEEP:
      begin
        // enabled source wakes regardless of global enable
        if (wake_req)
        begin
          st_d.sleeping = 1'b0;
          st_d.fsm = ic_pkg::IC_WAKE;
        end
      end
      ic_pkg::IC_WAKE:
      begin
        // one instruction after sleep retires before any branch
        if (q4 && retire_in)
          st_d.fsm = ic_pkg::IC_RUN;
      end
      default: st_d.fsm = ic_pkg::IC_RUN;
    endcase
  end

  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q <= '0;
      st_q.ctrl <= `IC_CTRL_RST;
      st_q.fsm <= ic_pkg::IC_RUN;
    end
    else
      st_q <= st_d;
  end

  assign prdata_out = st_q.rdata;
  assign pready_out = st_q.ready;
  assign pslverr_out = st_q.slverr;
  assign flush_out = st_q.flush;
  assign push_pc_out = st_q.push;
  assign pop_pc_out = st_q.pop;
  assign load_vec_out = st_q.ldvec;
  assign vector_out = `IC_VECTOR;
  assign restore_out = st_q.restore;
  assign restore_ctx_out = st_q.shw;
  assign core_sleep_out = st_q.sleeping;
  assign ctrl_out = st_q.ctrl;

  AST_RESET_CLEAR: assert property (@(posedge mclk_in) $fell(rst_in) |-> st_q.ctrl == 8'h00)
    else $error("control not cleared by reset");
  AST_NO_REDIRECT_GIE_OFF: assert property (@(posedge mclk_in) disable iff (rst_in)
    !st_q.ctrl[7] && st_q.fsm == ic_pkg::IC_RUN |=> !st_q.flush)
    else $error("redirect while global enable clear");
  AST_ENTRY_CLEARS_GIE: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(st_q.flush) |-> !st_q.ctrl[7] && st_q.push)
    else $error("entry without clearing global enable");
  AST_VECTOR_AFTER_FLUSH: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q.flush |-> ##12 st_q.ldvec)
    else $error("vector not loaded twelve cycles after flush");
  AST_RETURN_SETS_GIE: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q.pop |-> st_q.restore && st_q.ctrl[7])
    else $error("return did not restore and enable");
  AST_TMR_FLAG: assert property (@(posedge mclk_in) disable iff (rst_in)
    timer0_counter_ovf_in |=> st_q.ctrl[2])
    else $error("timer0 flag lost");
  AST_EXT_Q1: assert property (@(posedge mclk_in) disable iff (rst_in)
    $rose(st_q.ctrl[1]) |-> $past(q1))
    else $error("pin flag set outside q1");
  AST_SHADOW_MASK: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q.push |-> (st_q.shw.st & 8'h18) == 8'h00)
    else $error("timeout or powerdown bit shadowed");
  // sequencing guards: a redirect needs a request, a wake never
  // branches before the instruction after sleep has retired
  AST_REDIRECT_NEEDS_REQ: assert property (@(posedge mclk_in) disable iff (rst_in)
    !req |=> !st_q.flush)
    else $error("redirect without enabled request");
  AST_WAKE_NO_BRANCH: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q.fsm == ic_pkg::IC_WAKE |=> !st_q.flush)
    else $error("branch before post-sleep instruction");
  AST_SLEEP_WAKE: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q.fsm == ic_pkg::IC_SLEEP && wake_req |=> st_q.fsm == ic_pkg::IC_WAKE && !st_q.sleeping)
    else $error("enabled source did not wake the core");
  AST_PIN_FLAG_RO: assert property (@(posedge mclk_in) disable iff (rst_in)
    wr_ctrl && !pc_event |=> st_q.ctrl[0] == $past(st_q.ctrl[0]))
    else $error("pin-change flag changed by software");
  AST_POP_ONE_CYCLE: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q.pop |=> !st_q.pop)
    else $error("return strobe longer than one cycle");
  AST_ENTRY_STATE: assert property (@(posedge mclk_in) disable iff (rst_in)
    st_q.flush |-> st_q.fsm == ic_pkg::IC_ENTER)
    else $error("flush without entry sequence");
endmodule
`default_nettype wire

// ### src/ic_cfg.svh
// constants for the interrupt controller: offsets, bit positions, timing
// assumes inclusion by bare name from ic_top, ic_qgen and the bench
`ifndef IC_CFG_SVH
`define IC_CFG_SVH
// apb byte offsets, one aligned word each
`define IC_OFS_CTRL 12'h000
`define IC_OFS_OPT 12'h004
`define IC_OFS_PGRP 12'h008
`define IC_OFS_CORE 12'h00C
`define IC_OFS_SHW_W 12'h010
`define IC_OFS_SHW_ST 12'h014
`define IC_OFS_SHW_BSR 12'h018
`define IC_OFS_SHW_FSRL 12'h01C
`define IC_OFS_SHW_FSRH 12'h020
`define IC_OFS_SHW_PCH 12'h024
// control register bit positions
`define IC_B_GIE 7
`define IC_B_PERIPH_GROUP_ENABLE 6
`define IC_B_T0IE 5
`define IC_B_EXIE 4
`define IC_B_PCIE 3
`define IC_B_T0IF 2
`define IC_B_EXIF 1
`define IC_B_PCIF 0
// control register reset value
`define IC_CTRL_RST 8'h00
// interrupt vector
`define IC_VECTOR 15'h0004
// status bits excluded from shadowing: timeout bit 4, powerdown bit 3
`define IC_ST_KEEP_MASK 8'h18
// instruction cycle in q phases
`define IC_QPH 4
// extra q4 edges spent in entry before the vector load
`define IC_ENTRY_WAIT 2'h2
`endif

// ### src/ic_pkg.sv
// types shared by the interrupt controller modules
// assumes ic_cfg.svh is on the include path
package ic_pkg;
  // core context saved on entry
  typedef struct packed {
    logic [7:0] w;
    logic [7:0] st;
    logic [7:0] bank_select_register;
    logic [7:0] fsrl;
    logic [7:0] fsrh;
    logic [7:0] pch;
  } ic_ctx_s;
  // apb request
  typedef struct packed {
    logic sel;
    logic en;
    logic wr;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ic_apb_s;
  typedef enum logic [1:0] {
    IC_RUN = 2'b00,
    IC_ENTER = 2'b01,
    IC_SLEEP = 2'b10,
    IC_WAKE = 2'b11
  } ic_state_e;
endpackage

// ### src/ic_qgen.sv
// q phase generator: splits the clock into four q phases
// assumes one clock; q1 and q4 come out as one-cycle enables
`timescale 1ns/100ps
`default_nettype none
`include "ic_cfg.svh"
module ic_qgen (
  input wire logic mclk_in,
  input wire logic rst_in,
  output logic q1_out,
  output logic q4_out
);
  typedef struct packed {
    logic [1:0] ph;
  } ic_qst_s;
  ic_qst_s st_q;
  ic_qst_s st_d;
  // phase counter wraps every instruction cycle
  always_comb
  begin
    st_d = st_q;
    st_d.ph = st_q.ph + 2'h1;
  end
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  assign q1_out = (st_q.ph == 2'h0);
  assign q4_out = (st_q.ph == 2'h3);
endmodule
`default_nettype wire

// ### src/ic_edge.sv
// external pin edge detector with two-flop synchroniser
// assumes the pin is asynchronous to mclk_in
`timescale 1ns/100ps
`default_nettype none
module ic_edge (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  input wire logic rise_sel_in,
  output logic edge_out
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } ic_est_s;
  ic_est_s st_q;
  ic_est_s st_d;
  // only s2 and s3 feed the edge compare; s1 is seen by s2 alone
  always_comb
  begin
    st_d = st_q;
    st_d.s1 = pin_in;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end
  // rising when select is one, falling when zero
  assign edge_out = rise_sel_in ? (st_q.s2 & ~st_q.s3) : (~st_q.s2 & st_q.s3);
endmodule
`default_nettype wire

// ### testbench/ic_core_model.sv
// core model: fixed context and the return instruction
// assumes the controller samples the return level at q4
`timescale 1ns/100ps
`default_nettype none
module ic_core_model (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic ret_req_in,
  output ic_pkg::ic_ctx_s ctx_out,
  output logic ret_out
);
  logic [2:0] cnt_q;
  // held one whole instruction cycle so exactly one q4 sees it
  always_ff @(posedge mclk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_q <= 3'h0;
    else if (ret_req_in)
      cnt_q <= 3'h4;
    else if (cnt_q != 3'h0)
      cnt_q <= cnt_q - 3'h1;
  end
  assign ret_out = (cnt_q != 3'h0);
  // fixed context; status all ones so the shadow mask is exercised
  assign ctx_out = {8'h5A, 8'hFF, 8'h1F, 8'h3C, 8'h01, 8'h12};
endmodule
`default_nettype wire

// ### testbench/cpu_interrupt_controller_test.sv
// bench for the interrupt controller: apb tasks, scenarios, verdict
// assumes a zero-wait apb slave and the core model beside it
`timescale 1ns/100ps
`default_nettype none
`include "ic_cfg.svh"
module cpu_interrupt_controller_test;
  logic clk, rst, psel, pen, pwr, t0, pc, pin, rreq, er;
  logic slp_i, ret_i, pirq;
  logic prdy, perr, fl, push, pop, lv, rs, slp, ret;
  logic [11:0] pa;
  logic [31:0] pwd, prd, rd;
  logic [14:0] vec;
  logic [7:0] ctrl;
  ic_pkg::ic_ctx_s ctx, rctx;
  int n_errors, n_compared, n_fl, n_pu, n_lv, n_rs, cy;
  ic_top DUT (.mclk_in(clk), .rst_in(rst), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
    .pready_out(prdy), .pslverr_out(perr), .timer0_counter_ovf_in(t0),
    .pin_change_in(pc), .periph_irq_in(pirq), .ext_pin_in(pin),
    .sleep_instr_in(slp_i), .retire_in(ret_i), .return_from_irq_instr_in(ret),
    .core_ctx_in(ctx), .flush_out(fl), .push_pc_out(push), .pop_pc_out(pop),
    .load_vec_out(lv), .vector_out(vec), .restore_out(rs),
    .restore_ctx_out(rctx), .core_sleep_out(slp), .ctrl_out(ctrl));
  ic_core_model core (.mclk_in(clk), .rst_in(rst), .ret_req_in(rreq),
    .ctx_out(ctx), .ret_out(ret));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // one-cycle strobes counted mid-cycle where they are settled
  always @(negedge clk)
  begin
    n_fl += (fl === 1'b1);
    n_pu += (push === 1'b1);
    n_lv += (lv === 1'b1);
    n_rs += (rs === 1'b1 && pop === 1'b1);
  end
  task automatic test_done();
    $display("errors %0d compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // request held until pready is seen; data taken in that cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (i = 0; i < 8; i++)
    begin
      @(posedge clk);
      if (prdy === 1'b1)
        break;
    end
    rd = prd;
    er = perr;
    if (i == 8)
      chk(1'b0, 1'b1);
    psel <= 1'b0;
    pen <= 1'b0;
    if (i == 8)
      test_done();
  endtask
  task automatic wait_inc(ref int c, input int from);
    int i;
    for (i = 0; i < 40 && c == from; i++)
      @(posedge clk);
    chk(c != from, 1'b1);
    if (c == from)
      test_done();
  endtask
  task automatic set_pin(input logic v);
    @(posedge clk);
    pin <= v;
    repeat (8) @(posedge clk);
  endtask
  task automatic t_reset();
    apb(1'b0, `IC_OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h0FC, 32'hFF);
    chk(er, 1'b1);
    apb(1'b1, `IC_OFS_CTRL, 32'h01);
    apb(1'b0, `IC_OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
  endtask
  task automatic t_enter_return();
    @(posedge clk);
    t0 <= 1'b1;
    @(posedge clk);
    t0 <= 1'b0;
    apb(1'b0, `IC_OFS_CTRL, 32'h0);
    chk(rd, 32'h04);
    apb(1'b1, `IC_OFS_CTRL, 32'h84);
    repeat (16) @(posedge clk);
    chk(n_fl, 0);
    apb(1'b1, `IC_OFS_CTRL, 32'h24);
    repeat (16) @(posedge clk);
    chk(n_fl, 0);
    apb(1'b1, `IC_OFS_CTRL, 32'hA4);
    wait_inc(n_fl, 0);
    @(negedge clk);
    chk(ctrl[7], 1'b0);
    chk(n_pu, 1);
    wait_inc(n_lv, 0);
    chk(vec, 15'h0004);
    apb(1'b0, `IC_OFS_SHW_W, 32'h0);
    chk(rd, 32'h5A);
    apb(1'b0, `IC_OFS_SHW_ST, 32'h0);
    chk(rd, 32'hE7);
    apb(1'b1, `IC_OFS_SHW_W, 32'hC3);
    apb(1'b1, `IC_OFS_CTRL, 32'h20);
    @(posedge clk);
    rreq <= 1'b1;
    @(posedge clk);
    rreq <= 1'b0;
    wait_inc(n_rs, 0);
    @(negedge clk);
    chk(rctx.w, 8'hC3);
    chk(ctrl[7], 1'b1);
    repeat (16) @(posedge clk);
    chk(n_fl, 1);
  endtask
  task automatic t_latency();
    @(posedge clk);
    t0 <= 1'b1;
    @(posedge clk);
    t0 <= 1'b0;
    for (cy = 1; cy < 40 && n_lv == 1; cy++)
      @(posedge clk);
    // loop exits one edge after the vector cycle starts
    chk(cy >= 3 * `IC_QPH + 2 && cy <= 4 * `IC_QPH + 2, 1'b1);
    apb(1'b1, `IC_OFS_CTRL, 32'h0);
  endtask
  task automatic t_ext_pin();
    apb(1'b1, `IC_OFS_OPT, 32'h1);
    set_pin(1'b1);
    apb(1'b0, `IC_OFS_CTRL, 32'h0);
    chk(rd, 32'h02);
    apb(1'b1, `IC_OFS_CTRL, 32'h0);
    set_pin(1'b0);
    apb(1'b0, `IC_OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `IC_OFS_OPT, 32'h0);
    set_pin(1'b1);
    set_pin(1'b0);
    apb(1'b0, `IC_OFS_CTRL, 32'h0);
    chk(rd, 32'h02);
    apb(1'b1, `IC_OFS_CTRL, 32'h92);
    wait_inc(n_fl, 2);
  endtask
  task automatic t_pin_change();
    @(posedge clk);
    pc <= ~pc;
    repeat (12) @(posedge clk);
    apb(1'b0, `IC_OFS_CTRL, 32'h0);
    chk(rd[0], 1'b1);
  endtask
  // sleep twice: global enable off continues, on vectors after retire
  task automatic t_sleep();
    int i;
    apb(1'b1, `IC_OFS_CTRL, 32'h40);
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk);
      slp_i <= 1'b1;
      repeat (4) @(posedge clk);
      slp_i <= 1'b0;
      repeat (2) @(posedge clk);
      chk(slp, 1'b1);
      @(posedge clk);
      pirq <= 1'b1;
      repeat (16) @(posedge clk);
      chk(slp, 1'b0);
      apb(1'b0, `IC_OFS_CORE, 32'h0);
      chk(rd, 32'h3);
      chk(n_fl, 3);
      ret_i <= 1'b1;
      repeat (4) @(posedge clk);
      ret_i <= 1'b0;
      repeat (16) @(posedge clk);
      chk(n_fl, 3 + i);
      pirq <= 1'b0;
      apb(1'b1, `IC_OFS_CTRL, 32'hC0);
    end
  endtask
  // all inputs defined at time zero, reset held for eight cycles
  initial
  begin
    {rst, psel, pen, pwr, t0, pc, pin, rreq} = 8'h80;
    {slp_i, ret_i, pirq} = 3'h0;
    pa = 12'h000;
    pwd = 32'h0;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_enter_return();
    t_latency();
    t_ext_pin();
    t_pin_change();
    t_sleep();
    test_done();
  end
endmodule
`default_nettype wire
